// File: hdl/rps_device.sv
// Notes on behaviour
// - Run mode keeps core and peripheral clocks
// - Wait stops core clocks; interrupt wakes
// - Stop exits only on listed wake events
// - Software turns PLL off before stop
// - Software disables sleep; permanent until reset
// - Four reset sources, two async, two sync
// - Low supply holds reset until stable
// - Falling supply declares reset at lowest detector
// - Release after 64, 32, 32 clocks
// - Reset release on rising system clock
// - Only watchdog has its own clock
// - Security taken from configuration bytes
// - Secure mode disables core debug port
// - Reset sets debug read block from bytes
// - Test access port active in both modes
// - Lockout recovery erases whole flash
// - Seven-bit register overrides flash divider
// - Host loads divider into valid band
// - Erase starts on entering run-test idle
// - Host resets test port and chip after
`timescale 1ns/1ps
`include "rps_params.svh"
module rps_device
   import rps_pkg::*;
#(
   parameter logic [`RPS_DR_W-1:0] ID_CODE = 32'h1234_5001 // Arbitrary value
) (
   input wire logic ref_clk_in,
   input wire logic rst_in,
   rps_jtag_if.device jtag,
   input wire logic por18_low_in,
   input wire logic core22_low_in,
   input wire logic io27_low_in,
   input wire logic nonclocked_irq_pin_in,
   input wire logic can_activity_in,
   input wire logic watchdog_reset_source_in,
   input wire logic irq_pending_in,
   input wire logic stop_insn_in,
   input wire logic wait_insn_in,
   input wire logic ctrl_wr_in,
   input wire logic [`RPS_CTRL_W-1:0] ctrl_data_in,
   input wire logic [`RPS_SEC_W-1:0] sec_bytes_in,
   input wire logic erase_done_in,
   output rps_pwr_type power_mode_out,
   output logic core_clk_en_out,
   output logic mem_clk_en_out,
   output logic periph_clk_en_out,
   output logic watchdog_clk_en_out,
   output logic periph_reset_out,
   output logic core_reset_out,
   output logic debug_read_block_out,
   output logic core_debug_port_en_out,
   output logic flash_div_override_en_out,
   output logic flash_prescale_by_eight_out,
   output logic [5:0] flash_divide_count_out,
   output logic mass_erase_start_out,
   output logic recovery_done_out
);
   localparam rps_dev_type DEV_RST = '{
      pwr: PWR_RUN, rseq: RSQ_HOLD, seq_cnt: '0, core_clk: 1'b1, periph_clk: 1'b1,
      wdog_clk: 1'b1, periph_rst: 1'b1, core_rst: 1'b1, secure: 1'b1, tap: TAP_RESET,
      ir: `RPS_IR_IDCODE, default: '0};

   rps_dev_type s_reg;
   rps_dev_type s_next;
   logic [`RPS_SYNC_W-1:0] sy;
   logic s_tck, s_tms, s_tdi, s_trst_n, s_chip_n, s_p18, s_c22, s_i27, s_irq, s_can;
   logic tck_rise, tck_fall, por_cond, rst_src;
   rps_tap_type tap_nx;

   // Pins and the test clock come from outside this clock domain
   rps_sync2 #(.W(`RPS_SYNC_W), .RST_VAL(`RPS_SYNC_RST)) u_sync (
      .ref_clk_in(ref_clk_in),
      .rst_in(rst_in),
      .d_in({jtag.trst_n, jtag.chip_reset_n, por18_low_in, core22_low_in, io27_low_in,
             nonclocked_irq_pin_in, can_activity_in, jtag.tck, jtag.tms, jtag.tdi}),
      .q_out(sy)
   );
   assign {s_trst_n, s_chip_n, s_p18, s_c22, s_i27, s_irq, s_can, s_tck, s_tms, s_tdi} = sy;

   assign tck_rise = s_tck & ~s_reg.tck_q;
   assign tck_fall = ~s_tck & s_reg.tck_q;
   assign tap_nx = rps_tap_next(s_reg.tap, s_tms);
   // Once released, only the lowest detector counts, so a slow fall does not chatter
   assign por_cond = (s_reg.rseq == RSQ_HOLD) ? (s_p18 | s_c22 | s_i27) : s_p18;
   assign rst_src = ~s_chip_n | por_cond | watchdog_reset_source_in | s_reg.sw_rst;

   always_comb begin
      s_next = s_reg;
      s_next.erase_start = 1'b0;
      s_next.tck_q = s_tck;
      if (rst_src) begin
         s_next.rseq = RSQ_HOLD;
         s_next.seq_cnt = '0;
         s_next.periph_rst = 1'b1;
         s_next.core_rst = 1'b1;
         s_next.pwr = PWR_RUN;
         s_next.wait_dis = 1'b0;
         s_next.stop_dis = 1'b0;
         s_next.perm = 1'b0;
         s_next.sw_rst = 1'b0;
         s_next.erase_done = 1'b0;
      end else begin
         case (s_reg.rseq)
            RSQ_HOLD: begin
               s_next.rseq = RSQ_STAB;
            end
            RSQ_STAB: begin
               s_next.seq_cnt = s_reg.seq_cnt + 7'h01;
               if (s_reg.seq_cnt == `RPS_STAB_CYCLES - 7'h01) begin
                  s_next.rseq = RSQ_PERIPH;
                  s_next.seq_cnt = '0;
                  s_next.periph_rst = 1'b0;
                  // Flash hands the core its read block as peripherals leave reset
                  s_next.secure = sec_bytes_in[`RPS_SEC_FIELD] != `RPS_SEC_OPEN;
               end
            end
            RSQ_PERIPH: begin
               s_next.seq_cnt = s_reg.seq_cnt + 7'h01;
               if (s_reg.seq_cnt == `RPS_PERIPH_CYCLES - 7'h01) begin
                  s_next.rseq = RSQ_CORE;
                  s_next.seq_cnt = '0;
               end
            end
            RSQ_CORE: begin
               s_next.seq_cnt = s_reg.seq_cnt + 7'h01;
               if (s_reg.seq_cnt == `RPS_CORE_CYCLES - 7'h01) begin
                  s_next.rseq = RSQ_RUN;
                  s_next.core_rst = 1'b0;
               end
            end
            default: begin
               if (ctrl_wr_in) begin
                  if (!s_reg.perm) begin
                     s_next.wait_dis = ctrl_data_in[`RPS_CTRL_WAIT_DIS];
                     s_next.stop_dis = ctrl_data_in[`RPS_CTRL_STOP_DIS];
                     s_next.perm = ctrl_data_in[`RPS_CTRL_PERM];
                  end
                  s_next.sw_rst = ctrl_data_in[`RPS_CTRL_SW_RST];
               end
               case (s_reg.pwr)
                  PWR_RUN: begin
                     if (stop_insn_in && !s_reg.stop_dis) begin
                        s_next.pwr = PWR_STOP;
                     end else if (wait_insn_in && !s_reg.wait_dis) begin
                        s_next.pwr = PWR_WAIT;
                     end
                  end
                  PWR_WAIT: begin
                     if (irq_pending_in) begin
                        s_next.pwr = PWR_RUN;
                     end
                  end
                  default: begin
                     // CAN wake follows the synchronised activity level; the frame that woke us is not received
                     if (s_can || s_irq) begin
                        s_next.pwr = PWR_RUN;
                     end
                  end
               endcase
            end
         endcase
      end
      s_next.core_clk = s_next.pwr == PWR_RUN;
      s_next.periph_clk = s_next.pwr != PWR_STOP;
      // Watchdog keeps its own clock in every mode
      s_next.wdog_clk = 1'b1;

      // Test port runs regardless of security and chip reset
      if (!s_trst_n) begin
         s_next.tap = TAP_RESET;
         s_next.ir = `RPS_IR_IDCODE;
      end else if (tck_rise) begin
         case (s_reg.tap)
            TAP_RESET: s_next.ir = `RPS_IR_IDCODE;
            TAP_CAP_IR: s_next.ir_sh = `RPS_IR_CAPTURE;
            TAP_SHIFT_IR: s_next.ir_sh = {s_tdi, s_reg.ir_sh[`RPS_IR_W-1:1]};
            TAP_UPD_IR: s_next.ir = s_reg.ir_sh;
            TAP_CAP_DR: begin
               if (s_reg.ir == `RPS_IR_IDCODE) begin
                  s_next.dr_sh = ID_CODE;
               end else if (s_reg.ir == `RPS_IR_LOCKOUT) begin
                  s_next.dr_sh = `RPS_DR_W'(s_reg.div);
               end else begin
                  s_next.dr_sh = '0;
               end
            end
            TAP_SHIFT_DR: begin
               if (s_reg.ir == `RPS_IR_IDCODE) begin
                  s_next.dr_sh = {s_tdi, s_reg.dr_sh[`RPS_DR_W-1:1]};
               end else if (s_reg.ir == `RPS_IR_LOCKOUT) begin
                  s_next.dr_sh = `RPS_DR_W'({s_tdi, s_reg.dr_sh[`RPS_DIV_W-1:1]});
               end else begin
                  s_next.dr_sh = `RPS_DR_W'(s_tdi);
               end
            end
            TAP_UPD_DR: begin
               if (s_reg.ir == `RPS_IR_LOCKOUT) begin
                  s_next.div = s_reg.dr_sh[`RPS_DIV_W-1:0];
                  s_next.div_ok = 1'b1;
               end
            end
            default: ;
         endcase
         s_next.tap = tap_nx;
         if (s_reg.tap == TAP_UPD_DR && tap_nx == TAP_IDLE && s_reg.ir == `RPS_IR_LOCKOUT
             && !s_reg.erase_busy) begin
            s_next.erase_start = 1'b1;
            s_next.erase_busy = 1'b1;
         end
      end else if (tck_fall) begin
         if (s_reg.tap == TAP_SHIFT_IR) begin
            s_next.tdo = s_reg.ir_sh[0];
         end else if (s_reg.tap == TAP_SHIFT_DR) begin
            s_next.tdo = s_reg.dr_sh[0];
         end else begin
            // Outside shifting show erase status, never a stale shift bit
            s_next.tdo = s_reg.erase_done;
         end
      end
      if (erase_done_in && s_reg.erase_busy) begin
         s_next.erase_busy = 1'b0;
         s_next.erase_done = 1'b1;
      end
      s_next.ovr_en = (s_next.ir == `RPS_IR_LOCKOUT) && s_next.div_ok;
      s_next.dbg_en = (s_next.ir == `RPS_IR_DEBUG) && !s_next.secure;
   end

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         s_reg <= DEV_RST;
      end else begin
         s_reg <= s_next;
      end
   end

   assign jtag.tdo = s_reg.tdo;
   assign power_mode_out = s_reg.pwr;
   assign core_clk_en_out = s_reg.core_clk;
   assign mem_clk_en_out = s_reg.core_clk;
   assign periph_clk_en_out = s_reg.periph_clk;
   assign watchdog_clk_en_out = s_reg.wdog_clk;
   assign periph_reset_out = s_reg.periph_rst;
   assign core_reset_out = s_reg.core_rst;
   assign debug_read_block_out = s_reg.secure;
   assign core_debug_port_en_out = s_reg.dbg_en;
   assign flash_div_override_en_out = s_reg.ovr_en;
   assign flash_prescale_by_eight_out = s_reg.div[`RPS_DIV_PRESCALE];
   assign flash_divide_count_out = s_reg.div[`RPS_DIV_COUNT];
   assign mass_erase_start_out = s_reg.erase_start;
   assign recovery_done_out = s_reg.erase_done;
endmodule

// File: hdl/rps_host.sv
`timescale 1ns/1ps
`include "rps_params.svh"
module rps_host
   import rps_pkg::*;
(
   input wire logic ref_clk_in,
   input wire logic rst_in,
   rps_jtag_if.host jtag,
   input wire logic recover_start_in,
   input wire logic [`RPS_DIV_W-1:0] div_value_in,
   output logic busy_out,
   output logic done_out
);
   localparam rps_host_type HOST_RST = '{ph: H_IDLE, tms: 1'b1, trst_n: 1'b1,
      chip_rst_n: 1'b1, default: '0};

   rps_host_type s_reg;
   rps_host_type s_next;
   logic tick, rise, fall, shifting;

   assign tick = s_reg.div_cnt == '0;
   assign rise = tick && !s_reg.tck;
   assign fall = tick && s_reg.tck;
   assign shifting = s_reg.ph inside {H_TO_IR, H_SHIFT_IR, H_TO_DR, H_SHIFT_DR, H_TO_IDLE};

   always_comb begin
      s_next = s_reg;
      s_next.div_cnt = tick ? `RPS_H_HALF : s_reg.div_cnt - 2'h1;
      if (tick) begin
         s_next.tck = !s_reg.tck;
      end
      case (s_reg.ph)
         H_IDLE: begin
            if (recover_start_in) begin
               s_next.ph = H_TRST;
               s_next.busy = 1'b1;
               s_next.done = 1'b0;
               s_next.dv = div_value_in;
               s_next.trst_n = 1'b0;
               s_next.tms = 1'b1;
               s_next.cnt = `RPS_H_TRST_TICKS;
            end
         end
         H_RTI: begin
            // Hold run-test idle until the device flags the erase as finished
            if (rise && jtag.tdo) begin
               s_next.ph = H_TRST_END;
               s_next.cnt = `RPS_H_TRST_TICKS;
            end
         end
         default: ;
      endcase
      if (fall) begin
         case (s_reg.ph)
            H_TRST: begin
               s_next.cnt = s_reg.cnt - 4'h1;
               if (s_reg.cnt == 4'h1) begin
                  s_next.trst_n = 1'b1;
                  s_next.ph = H_TO_IR;
                  s_next.pat = `RPS_H_PATH_TO_IR;
                  s_next.cnt = `RPS_H_LEN_TO_IR;
               end
            end
            H_TO_IR, H_TO_DR, H_TO_IDLE: s_next.tms = s_reg.pat[0];
            H_SHIFT_IR, H_SHIFT_DR: begin
               s_next.tdi = s_reg.pat[0];
               s_next.tms = s_reg.cnt == 4'h1;
            end
            H_RTI: s_next.tms = 1'b0;
            H_TRST_END: begin
               s_next.trst_n = 1'b0;
               s_next.tms = 1'b1;
               s_next.cnt = s_reg.cnt - 4'h1;
               if (s_reg.cnt == 4'h1) begin
                  s_next.trst_n = 1'b1;
                  s_next.ph = H_CHIP_RST;
                  s_next.cnt = `RPS_H_CHIP_RST_TICKS;
               end
            end
            H_CHIP_RST: begin
               s_next.chip_rst_n = 1'b0;
               s_next.cnt = s_reg.cnt - 4'h1;
               if (s_reg.cnt == 4'h1) begin
                  s_next.chip_rst_n = 1'b1;
                  s_next.ph = H_IDLE;
                  s_next.busy = 1'b0;
                  s_next.done = 1'b1;
               end
            end
            default: ;
         endcase
         if (shifting) begin
            s_next.pat = s_reg.pat >> 1;
            s_next.cnt = s_reg.cnt - 4'h1;
            if (s_reg.cnt == 4'h1) begin
               case (s_reg.ph)
                  H_TO_IR: begin
                     s_next.ph = H_SHIFT_IR;
                     s_next.pat = `RPS_DIV_W'(`RPS_IR_LOCKOUT);
                     s_next.cnt = `RPS_H_LEN_IR;
                  end
                  H_SHIFT_IR: begin
                     s_next.ph = H_TO_DR;
                     s_next.pat = `RPS_H_PATH_TO_DR;
                     s_next.cnt = `RPS_H_LEN_TO_DR;
                  end
                  H_TO_DR: begin
                     s_next.ph = H_SHIFT_DR;
                     s_next.pat = s_reg.dv;
                     s_next.cnt = `RPS_H_LEN_DR;
                  end
                  H_SHIFT_DR: begin
                     s_next.ph = H_TO_IDLE;
                     s_next.pat = `RPS_H_PATH_TO_IDLE;
                     s_next.cnt = `RPS_H_LEN_TO_IDLE;
                  end
                  default: s_next.ph = H_RTI;
               endcase
            end
         end
      end
   end

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         s_reg <= HOST_RST;
      end else begin
         s_reg <= s_next;
      end
   end

   assign jtag.tck = s_reg.tck;
   assign jtag.tms = s_reg.tms;
   assign jtag.tdi = s_reg.tdi;
   assign jtag.trst_n = s_reg.trst_n;
   assign jtag.chip_reset_n = s_reg.chip_rst_n;
   assign busy_out = s_reg.busy;
   assign done_out = s_reg.done;
endmodule

// File: hdl/rps_jtag_if.sv
`timescale 1ns/1ps
interface rps_jtag_if;
   logic tck;
   logic tms;
   logic tdi;
   logic tdo;
   logic trst_n;
   logic chip_reset_n;
   modport device (input tck, input tms, input tdi, input trst_n, input chip_reset_n,
      output tdo);
   modport host (output tck, output tms, output tdi, output trst_n, output chip_reset_n,
      input tdo);
endinterface

// File: hdl/rps_params.svh
`ifndef RPS_PARAMS_SVH
`define RPS_PARAMS_SVH
// Reset release windows, in system clocks
`define RPS_STAB_CYCLES 7'h40
`define RPS_PERIPH_CYCLES 7'h20
`define RPS_CORE_CYCLES 7'h20
// System control register fields
`define RPS_CTRL_W 4
`define RPS_CTRL_WAIT_DIS 0
`define RPS_CTRL_STOP_DIS 1
`define RPS_CTRL_PERM 2
`define RPS_CTRL_SW_RST 3
// Test access port instructions
`define RPS_IR_W 4
`define RPS_IR_IDCODE 4'h2
`define RPS_IR_DEBUG 4'h6
`define RPS_IR_LOCKOUT 4'h8
`define RPS_IR_BYPASS 4'hf
`define RPS_IR_CAPTURE 4'h1
`define RPS_DR_W 32
`define RPS_DIV_W 7
`define RPS_DIV_PRESCALE 6
`define RPS_DIV_COUNT 5:0
// Security field of the configuration bytes
`define RPS_SEC_FIELD 1:0
`define RPS_SEC_OPEN 2'h2
`define RPS_SEC_W 16
// Synchroniser width and reset level
`define RPS_SYNC_W 10
`define RPS_SYNC_RST 10'h3e0
// Debug host timing, in clocks and test clock ticks
`define RPS_H_HALF 2'h3
`define RPS_H_TRST_TICKS 4'h4
`define RPS_H_CHIP_RST_TICKS 4'h8
// Mode-select paths, first bit in the lsb
`define RPS_H_PATH_TO_IR 7'h06
`define RPS_H_LEN_TO_IR 4'h5
`define RPS_H_PATH_TO_DR 7'h03
`define RPS_H_LEN_TO_DR 4'h4
`define RPS_H_PATH_TO_IDLE 7'h01
`define RPS_H_LEN_TO_IDLE 4'h2
`define RPS_H_LEN_IR 4'h4
`define RPS_H_LEN_DR 4'h7
`endif

// File: hdl/rps_pkg.sv
package rps_pkg;
`include "rps_params.svh"
   typedef enum logic [1:0] {PWR_RUN, PWR_WAIT, PWR_STOP} rps_pwr_type;
   typedef enum logic [2:0] {RSQ_HOLD, RSQ_STAB, RSQ_PERIPH, RSQ_CORE, RSQ_RUN} rps_rseq_type;
   typedef enum logic [3:0] {
      TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
      TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR,
      TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
   } rps_tap_type;
   typedef enum logic [3:0] {
      H_IDLE, H_TRST, H_TO_IR, H_SHIFT_IR, H_TO_DR, H_SHIFT_DR, H_TO_IDLE, H_RTI,
      H_TRST_END, H_CHIP_RST
   } rps_hphase_type;

   typedef struct packed {
      rps_pwr_type pwr;
      rps_rseq_type rseq;
      logic [6:0] seq_cnt;
      logic wait_dis;
      logic stop_dis;
      logic perm;
      logic sw_rst;
      logic core_clk;
      logic periph_clk;
      logic wdog_clk;
      logic periph_rst;
      logic core_rst;
      logic secure;
      logic dbg_en;
      logic tck_q;
      rps_tap_type tap;
      logic [`RPS_IR_W-1:0] ir;
      logic [`RPS_IR_W-1:0] ir_sh;
      logic [`RPS_DR_W-1:0] dr_sh;
      logic [`RPS_DIV_W-1:0] div;
      logic div_ok;
      logic ovr_en;
      logic tdo;
      logic erase_start;
      logic erase_busy;
      logic erase_done;
   } rps_dev_type;

   typedef struct packed {
      rps_hphase_type ph;
      logic [1:0] div_cnt;
      logic tck;
      logic tms;
      logic tdi;
      logic trst_n;
      logic chip_rst_n;
      logic [`RPS_DIV_W-1:0] pat;
      logic [`RPS_DIV_W-1:0] dv;
      logic [3:0] cnt;
      logic busy;
      logic done;
   } rps_host_type;

   function automatic rps_tap_type rps_tap_next(input rps_tap_type st, input logic tms);
      case (st)
         TAP_RESET: rps_tap_next = tms ? TAP_RESET : TAP_IDLE;
         TAP_IDLE: rps_tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
         TAP_SEL_DR: rps_tap_next = tms ? TAP_SEL_IR : TAP_CAP_DR;
         TAP_CAP_DR: rps_tap_next = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
         TAP_SHIFT_DR: rps_tap_next = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
         TAP_EXIT1_DR: rps_tap_next = tms ? TAP_UPD_DR : TAP_PAUSE_DR;
         TAP_PAUSE_DR: rps_tap_next = tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
         TAP_EXIT2_DR: rps_tap_next = tms ? TAP_UPD_DR : TAP_SHIFT_DR;
         TAP_UPD_DR: rps_tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
         TAP_SEL_IR: rps_tap_next = tms ? TAP_RESET : TAP_CAP_IR;
         TAP_CAP_IR: rps_tap_next = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
         TAP_SHIFT_IR: rps_tap_next = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
         TAP_EXIT1_IR: rps_tap_next = tms ? TAP_UPD_IR : TAP_PAUSE_IR;
         TAP_PAUSE_IR: rps_tap_next = tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
         TAP_EXIT2_IR: rps_tap_next = tms ? TAP_UPD_IR : TAP_SHIFT_IR;
         default: rps_tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
      endcase
   endfunction
endpackage

// File: hdl/rps_sync2.sv
`timescale 1ns/1ps
module rps_sync2 #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic ref_clk_in,
   input wire logic rst_in,
   input wire logic [W-1:0] d_in,
   output logic [W-1:0] q_out
);
   logic [W-1:0] meta_reg;

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         meta_reg <= RST_VAL;
         q_out <= RST_VAL;
      end else begin
         meta_reg <= d_in;
         q_out <= meta_reg;
      end
   end
endmodule

// File: tb/reset_power_security_control_bench.sv
`timescale 1ns/1ps
module reset_power_security_control_bench;
   import rps_pkg::*;
   logic ref_clk_in = 1'b0, rst_in = 1'b1, por18_low_in = 1'b1, core22_low_in = 1'b0;
   logic io27_low_in = 1'b0, nonclocked_irq_pin_in = 1'b0, can_activity_in = 1'b0;
   logic watchdog_reset_source_in = 1'b0, irq_pending_in = 1'b0, stop_insn_in = 1'b0;
   logic wait_insn_in = 1'b0, ctrl_wr_in = 1'b0, erase_done_in = 1'b0, recover_start_in = 1'b0;
   logic [3:0] ctrl_data_in = 4'h0;
   logic [15:0] sec_bytes_in = 16'h0000;
   logic [6:0] div_value_in = 7'h00;
   rps_pwr_type power_mode_out;
   logic core_clk_en_out, mem_clk_en_out, periph_clk_en_out, watchdog_clk_en_out;
   logic periph_reset_out, core_reset_out, debug_read_block_out, core_debug_port_en_out;
   logic flash_div_override_en_out, flash_prescale_by_eight_out, mass_erase_start_out;
   logic recovery_done_out, busy_out, done_out, saw_rec = 1'b0;
   logic [5:0] flash_divide_count_out;
   logic [7:0] cap = 8'h00, erase_wait = 8'h00;
   int n_mismatch = 0, checks = 0, n_erase = 0, cycles = 0;
   rps_jtag_if jtag();
   rps_device i_rps_device (.*);
   rps_host i_rps_host (.*);
   rps_properties i_rps_properties (.chip_reset_n(jtag.chip_reset_n), .*);
   always #50 ref_clk_in = ~ref_clk_in;
   // Flash stand-in: erase finishes ten clocks after it starts
   always @(negedge ref_clk_in) begin
      erase_done_in <= (erase_wait == 8'h01);
      if (erase_wait != 8'h00) erase_wait <= erase_wait - 8'h01;
      if (mass_erase_start_out === 1'b1) erase_wait <= 8'h0a;
   end
   always @(negedge ref_clk_in) begin
      cycles++;
      if (recovery_done_out === 1'b1) saw_rec = 1'b1;
      if (mass_erase_start_out === 1'b1) begin
         n_erase++;
         cap = {flash_div_override_en_out, flash_prescale_by_eight_out, flash_divide_count_out};
      end
      if (cycles == 20000) begin
         n_mismatch++;
         end_sim();
      end
   end
   task automatic end_sim();
      if (n_mismatch == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic compare(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge ref_clk_in);
   endtask
   task automatic wait_run(output int n);
      n = 0;
      while (core_reset_out !== 1'b0 && n < 400) begin
         cyc(1);
         n++;
      end
   endtask
   task automatic insn(input logic stop);
      stop_insn_in = stop;
      wait_insn_in = !stop;
      cyc(1);
      stop_insn_in = 1'b0;
      wait_insn_in = 1'b0;
      cyc(1);
   endtask
   task automatic wr(input logic [3:0] d);
      ctrl_data_in = d;
      ctrl_wr_in = 1'b1;
      cyc(1);
      ctrl_wr_in = 1'b0;
      cyc(2);
   endtask
   task automatic t_boot();
      int n;
      cyc(20);
      compare(core_reset_out, 1'b1);
      por18_low_in = 1'b0;
      wait_run(n);
      compare(n >= 128 && n <= 136, 1'b1);
      compare(debug_read_block_out, 1'b1);
      compare(core_debug_port_en_out, 1'b0);
   endtask
   task automatic t_falling();
      int n;
      core22_low_in = 1'b1;
      io27_low_in = 1'b1;
      cyc(8);
      compare(core_reset_out, 1'b0);
      core22_low_in = 1'b0;
      io27_low_in = 1'b0;
      sec_bytes_in = 16'h0002;
      por18_low_in = 1'b1;
      cyc(4);
      por18_low_in = 1'b0;
      compare(core_reset_out, 1'b1);
      wait_run(n);
      compare(debug_read_block_out, 1'b0);
   endtask
   task automatic t_wait();
      compare({core_clk_en_out, mem_clk_en_out, periph_clk_en_out}, 3'h7);
      insn(1'b0);
      compare(power_mode_out, PWR_WAIT);
      compare({core_clk_en_out, mem_clk_en_out, periph_clk_en_out}, 3'h1);
      irq_pending_in = 1'b1;
      cyc(2);
      irq_pending_in = 1'b0;
      compare(power_mode_out, PWR_RUN);
   endtask
   task automatic t_stop();
      for (int i = 0; i < 2; i++) begin
         insn(1'b1);
         irq_pending_in = 1'b1;
         cyc(6);
         irq_pending_in = 1'b0;
         compare({power_mode_out, core_clk_en_out, mem_clk_en_out}, {PWR_STOP, 2'h0});
         nonclocked_irq_pin_in = (i == 0);
         can_activity_in = (i == 1);
         cyc(5);
         nonclocked_irq_pin_in = 1'b0;
         can_activity_in = 1'b0;
         cyc(2);
         compare(power_mode_out, PWR_RUN);
      end
   endtask
   task automatic t_disable();
      int n;
      wr(4'h2);
      insn(1'b1);
      compare(power_mode_out, PWR_RUN);
      wr(4'h5);
      wr(4'h0);
      insn(1'b0);
      compare(power_mode_out, PWR_RUN);
      wr(4'h8);
      compare(periph_reset_out, 1'b1);
      wait_run(n);
      insn(1'b0);
      compare(power_mode_out, PWR_WAIT);
      irq_pending_in = 1'b1;
      cyc(2);
      irq_pending_in = 1'b0;
      watchdog_reset_source_in = 1'b1;
      cyc(1);
      watchdog_reset_source_in = 1'b0;
      cyc(2);
      compare(core_reset_out, 1'b1);
      wait_run(n);
   endtask
   task automatic t_recover(input logic [6:0] div);
      int n;
      div_value_in = div;
      recover_start_in = 1'b1;
      cyc(1);
      recover_start_in = 1'b0;
      saw_rec = 1'b0;
      compare(busy_out, 1'b1);
      n = n_erase;
      for (int i = 0; i < 3000 && done_out !== 1'b1; i++) cyc(1);
      compare(n_erase, n + 1);
      compare(cap, {1'b1, div});
      compare(saw_rec, 1'b1);
      compare(core_reset_out, 1'b1);
      wait_run(n);
   endtask
   initial begin
      cyc(6);
      rst_in = 1'b0;
      t_boot();
      t_falling();
      t_wait();
      t_stop();
      t_disable();
      t_recover(7'h13);
      t_recover(7'h49);
      end_sim();
   end
endmodule

// File: tb/rps_properties.sv
`timescale 1ns/1ps
module rps_properties
   import rps_pkg::*;
(
   input wire logic ref_clk_in,
   input wire logic rst_in,
   input wire logic chip_reset_n,
   input wire rps_pwr_type power_mode_out,
   input wire logic core_clk_en_out,
   input wire logic mem_clk_en_out,
   input wire logic periph_clk_en_out,
   input wire logic watchdog_clk_en_out,
   input wire logic periph_reset_out,
   input wire logic core_reset_out,
   input wire logic debug_read_block_out,
   input wire logic core_debug_port_en_out,
   input wire logic flash_div_override_en_out,
   input wire logic mass_erase_start_out,
   input wire logic irq_pending_in,
   input wire logic nonclocked_irq_pin_in,
   input wire logic can_activity_in,
   input wire logic watchdog_reset_source_in,
   input wire logic por18_low_in
);
   logic [15:0] stab_cnt_reg;
   logic [15:0] rel_cnt_reg;
   // Cycles with both resets held, and with only the core held
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         stab_cnt_reg <= 16'h0000;
         rel_cnt_reg <= 16'h0000;
      end else begin
         stab_cnt_reg <= (periph_reset_out && core_reset_out) ? stab_cnt_reg + 16'h0001 : 16'h0000;
         rel_cnt_reg <= (!periph_reset_out && core_reset_out) ? rel_cnt_reg + 16'h0001 : 16'h0000;
      end
   end
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (rst_in);
   // Four quiet samples flush the wake synchronisers
   sequence quiet_stop;
      (power_mode_out == PWR_STOP && !nonclocked_irq_pin_in && !can_activity_in
         && !watchdog_reset_source_in && chip_reset_n && !por18_low_in)[*4];
   endsequence
   AST_RUN_CLOCKS: assert property (power_mode_out == PWR_RUN |->
      core_clk_en_out && mem_clk_en_out && periph_clk_en_out) else $error("run clocks off");
   AST_WAIT_CLOCKS: assert property (power_mode_out == PWR_WAIT |->
      !core_clk_en_out && !mem_clk_en_out && periph_clk_en_out) else $error("wait clocks");
   AST_WAIT_WAKE: assert property (power_mode_out == PWR_WAIT && irq_pending_in |=>
      power_mode_out == PWR_RUN) else $error("wait not woken");
   AST_STOP_CLOCKS: assert property (power_mode_out == PWR_STOP |->
      !core_clk_en_out && !mem_clk_en_out) else $error("stop clocks");
   AST_STOP_HOLD: assert property (quiet_stop |=> power_mode_out == PWR_STOP)
      else $error("stop left without wake");
   AST_WDOG_CLOCK: assert property (watchdog_clk_en_out) else $error("watchdog clock off");
   AST_STAB_WINDOW: assert property ($fell(periph_reset_out) |-> stab_cnt_reg >= 16'h0040)
      else $error("stabilisation window short");
   AST_CORE_WINDOW: assert property ($fell(core_reset_out) |-> rel_cnt_reg == 16'h0040)
      else $error("core release window wrong");
   AST_ERASE_PULSE: assert property (mass_erase_start_out |=> !mass_erase_start_out)
      else $error("erase start not a pulse");
   AST_ERASE_DIVIDER: assert property (mass_erase_start_out |-> flash_div_override_en_out)
      else $error("erase without divider");
   AST_SECURE_DEBUG: assert property (debug_read_block_out |-> !core_debug_port_en_out)
      else $error("debug open while secure");
endmodule
